// >>> rtl/tws_consts.svh
// constants for the three-wire serial port: offsets, field positions, resets, divider counts
// assumes inclusion by bare name from rtl files; definitions only
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// register indices; one word per register, so the apb byte address is four times the index
`define TWS_IDX_SYNC_MODE    16'hFF72
`define TWS_IDX_SHIFT        16'hFF74
`define TWS_IDX_STATUS       16'hFF76
`define TWS_IDX_ASYNC_MODE   16'hFFA0
`define TWS_ADDR_SYNC_MODE   ({`TWS_IDX_SYNC_MODE, 2'b00})
`define TWS_ADDR_SHIFT       ({`TWS_IDX_SHIFT, 2'b00})
`define TWS_ADDR_STATUS      ({`TWS_IDX_STATUS, 2'b00})
`define TWS_ADDR_ASYNC_MODE  ({`TWS_IDX_ASYNC_MODE, 2'b00})

// reset values and writable-bit masks
`define TWS_SYNC_MODE_RST    8'h00
`define TWS_ASYNC_MODE_RST   8'h00
`define TWS_SHIFT_RST        8'h00
`define TWS_SYNC_MODE_MASK   8'h96
`define TWS_ASYNC_MODE_MASK  8'hFE

// sync mode register fields
`define TWS_BIT_SYNC_EN      7
`define TWS_BIT_DIV_SEL      4
`define TWS_BIT_ORDER        2
`define TWS_BIT_CLK_SRC      1

// async mode register fields
`define TWS_BIT_TX_EN        7
`define TWS_BIT_RX_EN        6
`define TWS_BIT_PAR_HI       5
`define TWS_BIT_PAR_LO       4
`define TWS_BIT_CHAR_LEN     3
`define TWS_BIT_STOP_LEN     2
`define TWS_BIT_ERR_MASK     1

// status register fields
`define TWS_BIT_ST_BUSY      0
`define TWS_BIT_ST_PEND      1
`define TWS_BIT_ST_SCLK      2

// serial clock half periods in mclk cycles (divide by 4 and by 8)
`define TWS_HALF_DIV4        3'd2
`define TWS_HALF_DIV8        3'd4

// transfer and frame sizes
`define TWS_LAST_BIT         3'd7
`define TWS_DATA_BITS_SHORT  4'h7
`define TWS_DATA_BITS_LONG   4'h8
`define TWS_STOP_BITS_ONE    2'h1
`define TWS_STOP_BITS_TWO    2'h2

`endif

// >>> rtl/tws_pkg.sv
// types shared by the three-wire serial port files
// assumes nothing beyond a SystemVerilog compiler
package tws_pkg;

	typedef enum logic [2:0] {
		REG_NONE,
		REG_SYNC_MODE,
		REG_SHIFT,
		REG_STATUS,
		REG_ASYNC_MODE
	} tws_reg_e;

	// order matches the two-bit parity field
	typedef enum logic [1:0] {
		PAR_NONE,
		PAR_ZERO,
		PAR_ODD,
		PAR_EVEN
	} tws_parity_e;

	typedef logic [7:0] tws_byte_t;

endpackage

// >>> rtl/tws_sclk_div.sv
// half-period tick generator for the internal serial clock
// assumes run is synchronous to mclk; tick is a one-cycle pulse
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_sclk_div #(
	parameter int CNT_W = 3
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// control
	input  wire logic run,
	input  wire logic divSel,
	// tick out
	output logic      halfTick
);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] halfLast;

	initial begin
		if (CNT_W < 3)
			$error("tws_sclk_div: CNT_W too small for the divide-by-8 half period");
	end

	// counter clears while stopped so the first edge always comes one full half period late
	assign halfLast = divSel ? CNT_W'(`TWS_HALF_DIV8 - 3'd1) : CNT_W'(`TWS_HALF_DIV4 - 3'd1);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n) begin
			cnt_reg  <= '0;
			halfTick <= 1'b0;
		end else if (!run) begin
			cnt_reg  <= '0;
			halfTick <= 1'b0;
		end else if (cnt_reg == halfLast) begin
			cnt_reg  <= '0;
			halfTick <= 1'b1;
		end else begin
			cnt_reg  <= cnt_reg + CNT_W'(1);
			halfTick <= 1'b0;
		end
	end

endmodule // tws_sclk_div

// >>> rtl/tws_serial_port.sv
// three-wire serial port with mode registers, reached over apb
// assumes apb master on mclk; serial clock and input pins are asynchronous
//
// Summary of operation
// - enable bit low stops the three-wire function; no shifting happens.
// - write to shift register starts transfer if enabled and clock idle high.
// - internal clock is mclk divided by 4 or by 8 per divider bit.
// - bit order select: 0 sends msb first, 1 sends lsb first.
// - clock source select: 0 takes external clock pin, 1 internal divider.
// - tx and rx enable bits switch their pins between port and serial.
// - parity field selects none, forced zero, odd or even parity.
// - character length bit selects 7 or 8 data bits.
// - stop length bit selects one or two transmitted stop bits.
// - error mask bit set suppresses reception-complete interrupt on error.
// - data moves in 8-bit units, one bit per serial clock.
// - shift after rising serial clock; output latch loads on fall and drives serial out pin.
// - serial in pin is captured on each rising serial clock edge.
// - after eighth bit shifting stops and transfer-done interrupt pulses.
// - byte written while disabled is dropped, even if enabled later.
// - with external clock, further writes leave the loaded byte unchanged.
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_serial_port #(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// three-wire serial pins
	input  wire logic                 serialClkIn,
	output logic                      serialClkOut,
	output logic                      serialClkOe,
	output logic                      serialOut,
	input  wire logic                 serialIn,
	output logic                      syncXferDoneIrq,
	// async unit pin function and frame setup
	output logic                      txPinSerial,
	output logic                      rxPinSerial,
	output tws_pkg::tws_parity_e      paritySel,
	output logic      [3:0]           dataBits,
	output logic      [1:0]           stopBits,
	// async unit receive events
	input  wire logic                 rxFrameDone,
	input  wire logic                 rxError,
	output logic                      rxDoneIrq
);
	import tws_pkg::*;

	initial begin
		if (ADDR_W < 18 || ADDR_W > 32)
			$error("tws_serial_port: ADDR_W must be 18 to 32");
	end

	// register state
	tws_byte_t   syncMode_reg;
	tws_byte_t   asyncMode_reg;
	tws_byte_t   shift_reg;
	logic        pending_reg;
	logic        busy_reg;
	logic [2:0]  bitCnt_reg;
	logic        capEv_reg;
	logic        clkOut_reg;

	// pin synchronisers
	logic        sclkSync1;
	logic        sclkSync2;
	logic        sclkPrev;
	logic        siSync1;
	logic        siSync2;

	// decoded controls
	logic        syncEn;
	logic        divSel;
	logic        lsbFirst;
	logic        intClk;
	logic        halfTick;
	logic        fallEv;
	logic        riseEv;
	logic        startXfer;
	logic        apbDone;
	logic        wrShift;
	logic        acceptWr;
	tws_reg_e    regSel;
	logic [31:0] readValue;

	function automatic tws_reg_e decodeAddr(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`TWS_ADDR_SYNC_MODE))
			return REG_SYNC_MODE;
		else if (a == ADDR_W'(`TWS_ADDR_SHIFT))
			return REG_SHIFT;
		else if (a == ADDR_W'(`TWS_ADDR_STATUS))
			return REG_STATUS;
		else if (a == ADDR_W'(`TWS_ADDR_ASYNC_MODE))
			return REG_ASYNC_MODE;
		else
			return REG_NONE;
	endfunction

	assign syncEn   = syncMode_reg[`TWS_BIT_SYNC_EN];
	assign divSel   = syncMode_reg[`TWS_BIT_DIV_SEL];
	assign lsbFirst = syncMode_reg[`TWS_BIT_ORDER];
	assign intClk   = syncMode_reg[`TWS_BIT_CLK_SRC];
	assign regSel   = decodeAddr(paddr);
	assign apbDone  = psel && penable && pready;
	assign wrShift  = apbDone && pwrite && (regSel == REG_SHIFT);

	// a held byte blocks overwrites until it has gone out; disabled writes are lost
	assign acceptWr = wrShift && syncEn && !pending_reg && !busy_reg && !capEv_reg;

	// start only when the clock line idles high: internal is high whenever idle
	assign startXfer = syncEn && pending_reg && !busy_reg && (intClk || sclkSync2);

	// edge events: internal from the divider, external from the synchronised pin
	assign fallEv = busy_reg && (intClk ? (clkOut_reg && halfTick)
	                                    : (sclkPrev && !sclkSync2));
	assign riseEv = busy_reg && (intClk ? (!clkOut_reg && halfTick)
	                                    : (!sclkPrev && sclkSync2));

	tws_sclk_div #(
		.CNT_W    (3)
	) u_div (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.run      (busy_reg && intClk),
		.divSel   (divSel),
		.halfTick (halfTick)
	);

	// two-flop synchronisers; only the second stage feeds logic
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n) begin
			sclkSync1 <= 1'b1;
			sclkSync2 <= 1'b1;
			sclkPrev  <= 1'b1;
			siSync1   <= 1'b0;
			siSync2   <= 1'b0;
		end else begin
			sclkSync1 <= serialClkIn;
			sclkSync2 <= sclkSync1;
			sclkPrev  <= sclkSync2;
			siSync1   <= serialIn;
			siSync2   <= siSync1;
		end
	end

	// apb: one wait state, answer registered
	always_comb
	begin
		readValue = 32'h0000_0000;
		case (regSel)
			REG_SYNC_MODE:  readValue = {24'h00_0000, syncMode_reg};
			REG_SHIFT:      readValue = {24'h00_0000, shift_reg};
			REG_STATUS:     readValue = {29'h0000_0000, clkOut_reg, pending_reg, busy_reg};
			REG_ASYNC_MODE: readValue = {24'h00_0000, asyncMode_reg};
			default:        readValue = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			prdata  <= (psel && penable && !pready && !pwrite) ? readValue : 32'h0000_0000;
			pslverr <= psel && penable && !pready && (regSel == REG_NONE);
		end
	end

	// mode registers; fixed-zero bits never store, so they read back as zero
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n) begin
			syncMode_reg  <= `TWS_SYNC_MODE_RST;
			asyncMode_reg <= `TWS_ASYNC_MODE_RST;
		end else if (apbDone && pwrite) begin
			if (regSel == REG_SYNC_MODE)
				syncMode_reg <= pwdata[7:0] & `TWS_SYNC_MODE_MASK;
			else if (regSel == REG_ASYNC_MODE)
				asyncMode_reg <= pwdata[7:0] & `TWS_ASYNC_MODE_MASK;
		end
	end

	// transfer engine
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n) begin
			shift_reg       <= `TWS_SHIFT_RST;
			pending_reg     <= 1'b0;
			busy_reg        <= 1'b0;
			bitCnt_reg      <= 3'd0;
			capEv_reg       <= 1'b0;
			syncXferDoneIrq <= 1'b0;
		end else if (!syncEn) begin
			// disabling aborts any transfer and drops a waiting byte
			pending_reg     <= 1'b0;
			busy_reg        <= 1'b0;
			bitCnt_reg      <= 3'd0;
			capEv_reg       <= 1'b0;
			syncXferDoneIrq <= 1'b0;
		end else begin
			syncXferDoneIrq <= 1'b0;
			// input pin is two flops late; take it a cycle after the rise so divide-by-4 still fits
			capEv_reg       <= riseEv;
			if (capEv_reg) begin
				if (lsbFirst)
					shift_reg <= {siSync2, shift_reg[7:1]};
				else
					shift_reg <= {shift_reg[6:0], siSync2};
			end
			if (acceptWr) begin
				shift_reg   <= pwdata[7:0];
				pending_reg <= 1'b1;
			end
			if (startXfer) begin
				pending_reg <= 1'b0;
				busy_reg    <= 1'b1;
				bitCnt_reg  <= 3'd0;
			end
			if (riseEv) begin
				bitCnt_reg <= bitCnt_reg + 3'd1;
				if (bitCnt_reg == `TWS_LAST_BIT) begin
					busy_reg        <= 1'b0;
					syncXferDoneIrq <= 1'b1;
				end
			end
		end
	end

	// output latch loads the leading bit on each falling edge
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			serialOut <= 1'b0;
		else if (fallEv)
			serialOut <= lsbFirst ? shift_reg[0] : shift_reg[7];
	end

	// internal serial clock; idles high so a later start sees a clean first fall
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n) begin
			clkOut_reg   <= 1'b1;
			serialClkOut <= 1'b1;
			serialClkOe  <= 1'b0;
		end else begin
			if (!busy_reg || !intClk)
				clkOut_reg <= 1'b1;
			else if (halfTick)
				clkOut_reg <= !clkOut_reg;
			serialClkOut <= (!busy_reg || !intClk) ? 1'b1 : (halfTick ? !clkOut_reg : clkOut_reg);
			serialClkOe  <= syncEn && intClk;
		end
	end

	// async unit setup outputs and receive interrupt gating
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n) begin
			txPinSerial <= 1'b0;
			rxPinSerial <= 1'b0;
			paritySel   <= PAR_NONE;
			dataBits    <= `TWS_DATA_BITS_SHORT;
			stopBits    <= `TWS_STOP_BITS_ONE;
			rxDoneIrq   <= 1'b0;
		end else begin
			txPinSerial <= asyncMode_reg[`TWS_BIT_TX_EN];
			rxPinSerial <= asyncMode_reg[`TWS_BIT_RX_EN];
			paritySel   <= tws_parity_e'(asyncMode_reg[`TWS_BIT_PAR_HI:`TWS_BIT_PAR_LO]);
			dataBits    <= asyncMode_reg[`TWS_BIT_CHAR_LEN] ? `TWS_DATA_BITS_LONG
			                                                : `TWS_DATA_BITS_SHORT;
			stopBits    <= asyncMode_reg[`TWS_BIT_STOP_LEN] ? `TWS_STOP_BITS_TWO
			                                                : `TWS_STOP_BITS_ONE;
			rxDoneIrq   <= rxFrameDone && asyncMode_reg[`TWS_BIT_RX_EN]
			               && !(rxError && asyncMode_reg[`TWS_BIT_ERR_MASK]);
		end
	end

	// checks
	a_stop_when_off: assert property (@(posedge mclk) disable iff (!rst_n)
		!syncEn |=> !busy_reg && !pending_reg)
		else $error("transfer still active while disabled");

	a_start_internal: assert property (@(posedge mclk) disable iff (!rst_n)
		syncEn && intClk && pending_reg && !busy_reg |=> busy_reg && !pending_reg)
		else $error("pending byte did not start with internal clock");

	a_div_four_half: assert property (@(posedge mclk) disable iff (!rst_n)
		fallEv && intClk && !divSel ##1 (syncEn && intClk && !divSel)[*2] |-> riseEv)
		else $error("divide-by-4 rise not two cycles after fall");

	a_div_eight_half: assert property (@(posedge mclk) disable iff (!rst_n)
		fallEv && intClk && divSel ##1 (syncEn && intClk && divSel)[*4] |-> riseEv)
		else $error("divide-by-8 rise not four cycles after fall");

	a_msb_first_out: assert property (@(posedge mclk) disable iff (!rst_n)
		fallEv && !lsbFirst |=> serialOut == $past(shift_reg[7]))
		else $error("msb-first output latch wrong");

	a_lsb_first_out: assert property (@(posedge mclk) disable iff (!rst_n)
		fallEv && lsbFirst |=> serialOut == $past(shift_reg[0]))
		else $error("lsb-first output latch wrong");

	a_ext_clk_undriven: assert property (@(posedge mclk) disable iff (!rst_n)
		!intClk |=> !serialClkOe)
		else $error("serial clock driven with external source");

	a_pin_function: assert property (@(posedge mclk) disable iff (!rst_n)
		!asyncMode_reg[`TWS_BIT_TX_EN] && !asyncMode_reg[`TWS_BIT_RX_EN]
		|=> !txPinSerial && !rxPinSerial)
		else $error("pins left in serial function while stopped");

	a_rx_err_masked: assert property (@(posedge mclk) disable iff (!rst_n)
		rxFrameDone && rxError && asyncMode_reg[`TWS_BIT_ERR_MASK] |=> !rxDoneIrq)
		else $error("masked error still raised reception interrupt");

	a_capture_input: assert property (@(posedge mclk) disable iff (!rst_n)
		capEv_reg && syncEn && !lsbFirst |=> shift_reg[0] == $past(siSync2))
		else $error("input bit not captured on rise");

	a_eighth_bit_done: assert property (@(posedge mclk) disable iff (!rst_n)
		syncEn && riseEv && bitCnt_reg == `TWS_LAST_BIT |=> syncXferDoneIrq && !busy_reg)
		else $error("transfer did not end after eighth bit");

	a_done_only_at_end: assert property (@(posedge mclk) disable iff (!rst_n)
		syncXferDoneIrq |-> $past(riseEv) && $past(bitCnt_reg) == `TWS_LAST_BIT)
		else $error("done pulse without eighth bit");

	a_disabled_write_lost: assert property (@(posedge mclk) disable iff (!rst_n)
		wrShift && !syncEn |=> !pending_reg ##1 !busy_reg)
		else $error("byte written while disabled was kept");

	a_loaded_byte_kept: assert property (@(posedge mclk) disable iff (!rst_n)
		wrShift && !intClk && (pending_reg || busy_reg) && !capEv_reg |=> shift_reg == $past(shift_reg))
		else $error("loaded byte overwritten with external clock");

	a_idle_clock_high: assert property (@(posedge mclk) disable iff (!rst_n)
		intClk && !busy_reg |=> clkOut_reg ##1 (busy_reg || serialClkOut))
		else $error("internal serial clock not high while idle");

endmodule // tws_serial_port

// >>> verification/tws_peer_model.sv
// far-side peer of the three-wire port: shifts its own byte out, collects the device's byte
// assumes one device on the link; clock pin is fed from the device or from this model
`timescale 1ns/1ps

module tws_peer_model (
	// clock
	input  wire logic       mclk,
	// device pins
	input  wire logic       serialClkOut,
	input  wire logic       serialClkOe,
	input  wire logic       serialOut,
	output logic            serialClkIn,
	output logic            serialIn,
	// test control
	input  wire logic       lsbFirst,
	input  wire logic       extGo,
	input  wire logic       arm,
	input  wire logic [7:0] txByte,
	output logic      [7:0] rxByte
);
	logic       extClk;
	logic [3:0] bitCnt;
	logic [3:0] holdCnt;

	initial
	begin
		extClk = 1'b1;
		serialIn = 1'b0;
		bitCnt = 4'h0;
		holdCnt = 4'h0;
	end

	// wire level: whoever enables drives the clock line
	assign serialClkIn = serialClkOe ? serialClkOut : extClk;

	// clock stands high outside frames; each phase 4 mclk, above the 3 the device needs
	always @(posedge extGo)
	begin
		repeat (8)
		begin
			repeat (4) @(posedge mclk);
			extClk <= 1'b0;
			repeat (4) @(posedge mclk);
			extClk <= 1'b1;
		end
	end

	always @(posedge arm)
		bitCnt <= 4'h0;

	// new bit on every fall, in the same order the device uses
	always @(negedge serialClkIn)
	begin
		serialIn <= lsbFirst ? txByte[bitCnt[2:0]] : txByte[3'h7 - bitCnt[2:0]];
		holdCnt <= 4'h0;
	end

	// device data taken on the rise
	always @(posedge serialClkIn)
	begin
		rxByte <= lsbFirst ? {serialOut, rxByte[7:1]} : {rxByte[6:0], serialOut};
		bitCnt <= bitCnt + 4'h1;
	end

	// after the hold time the data line no longer shows the last bit
	always @(posedge mclk)
	begin
		if (bitCnt == 4'h8 && holdCnt < 4'h7)
			holdCnt <= holdCnt + 4'h1;
		if (bitCnt == 4'h8 && holdCnt == 4'h6)
			serialIn <= ~serialIn;
	end
endmodule // tws_peer_model

// >>> verification/tws_serial_port_tb.sv
// self-checking bench for the three-wire serial port over apb
// assumes the peer model file is compiled first; no other stimulus source
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_serial_port_tb;
	import tws_pkg::*;

	logic mclk, rst_n, psel, penable, pwrite, serialClkIn, serialIn, rxFrameDone, rxError;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, serialClkOut, serialClkOe, serialOut, syncXferDoneIrq;
	logic txPinSerial, rxPinSerial, rxDoneIrq, lsbFirst, extGo, arm, er;
	tws_parity_e paritySel;
	logic [3:0] dataBits;
	logic [1:0] stopBits;
	logic [7:0] peerTx, peerRx, v;
	int errTotal, checks, doneCnt, rxIrqCnt, lowCnt, cyc, base, lowBase;

	tws_serial_port u_tws_serial_port (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .serialClkIn(serialClkIn),
		.serialClkOut(serialClkOut), .serialClkOe(serialClkOe), .serialOut(serialOut),
		.serialIn(serialIn), .syncXferDoneIrq(syncXferDoneIrq), .txPinSerial(txPinSerial),
		.rxPinSerial(rxPinSerial), .paritySel(paritySel), .dataBits(dataBits),
		.stopBits(stopBits), .rxFrameDone(rxFrameDone), .rxError(rxError),
		.rxDoneIrq(rxDoneIrq));

	tws_peer_model u_tws_peer_model (.mclk(mclk), .serialClkOut(serialClkOut),
		.serialClkOe(serialClkOe), .serialOut(serialOut), .serialClkIn(serialClkIn),
		.serialIn(serialIn), .lsbFirst(lsbFirst), .extGo(extGo), .arm(arm),
		.txByte(peerTx), .rxByte(peerRx));

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// pulse and clock-low counters so one-cycle events are never missed
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (syncXferDoneIrq === 1'b1)
			doneCnt <= doneCnt + 1;
		if (rxDoneIrq === 1'b1)
			rxIrqCnt <= rxIrqCnt + 1;
		if (serialClkOe === 1'b1 && serialClkOut === 1'b0)
			lowCnt <= lowCnt + 1;
		if (cyc == 20000)
		begin
			errTotal++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			errTotal++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_done(input int target);
		int n;
		n = 0;
		while (doneCnt < target && n < 600)
		begin
			@(posedge mclk);
			n++;
		end
		repeat (6) @(posedge mclk);
	endtask

	task automatic rx_event(input logic e);
		@(posedge mclk);
		rxFrameDone <= 1'b1;
		rxError <= e;
		@(posedge mclk);
		rxFrameDone <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	initial
	begin
		{psel, penable, pwrite, rxFrameDone, rxError, lsbFirst, extGo, arm} = '0;
		{paddr, pwdata, peerTx} = '0;
		{errTotal, checks, doneCnt, rxIrqCnt, lowCnt, cyc} = '0;
		rst_n = 1'b0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		chk("idle clock", 32'h1, {31'h0, serialClkOut});
		chk("data bits", 32'h7, {28'h0, dataBits});
		chk("stop bits", 32'h1, {30'h0, stopBits});
		apb(1'b0, `TWS_ADDR_SYNC_MODE, 8'h00);
		chk("sync mode reset", 32'h0, rd);
		apb(1'b0, `TWS_ADDR_ASYNC_MODE, 8'h00);
		chk("async mode reset", 32'h0, rd);
		apb(1'b0, 18'h3FDF0, 8'h00);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		// every pin mode, parity code, length and stop choice
		for (int i = 0; i < 4; i++)
		begin
			v = {i[0], i[1], i[1], i[0], i[0], i[1], i[0], 1'b0};
			apb(1'b1, `TWS_ADDR_ASYNC_MODE, v);
			apb(1'b0, `TWS_ADDR_ASYNC_MODE, 8'h00);
			chk("async mode", {24'h0, v}, rd);
			chk("tx pin", {31'h0, i[0]}, {31'h0, txPinSerial});
			chk("rx pin", {31'h0, i[1]}, {31'h0, rxPinSerial});
			chk("parity", {30'h0, i[1], i[0]}, {30'h0, paritySel});
			chk("data bits", i[0] ? 32'h8 : 32'h7, {28'h0, dataBits});
			chk("stop bits", i[1] ? 32'h2 : 32'h1, {30'h0, stopBits});
		end
		apb(1'b1, `TWS_ADDR_ASYNC_MODE, 8'h40);
		rx_event(1'b1);
		chk("rx irq unmasked error", 32'h1, rxIrqCnt);
		apb(1'b1, `TWS_ADDR_ASYNC_MODE, 8'h42);
		rx_event(1'b1);
		chk("rx irq masked error", 32'h1, rxIrqCnt);
		rx_event(1'b0);
		chk("rx irq clean", 32'h2, rxIrqCnt);
		apb(1'b1, `TWS_ADDR_ASYNC_MODE, 8'h00);
		// byte loaded while stopped must never go out
		apb(1'b1, `TWS_ADDR_SHIFT, 8'h5A);
		apb(1'b1, `TWS_ADDR_SYNC_MODE, 8'h82);
		repeat (60) @(posedge mclk);
		chk("no transfer when stopped", 32'h0, doneCnt);
		chk("clock idle", 32'h1, {31'h0, serialClkOut});
		// internal clock, both dividers and both bit orders
		for (int k = 0; k < 4; k++)
		begin
			base = doneCnt;
			lowBase = lowCnt;
			lsbFirst <= k[1];
			peerTx <= 8'hC3 ^ k[7:0];
			arm <= 1'b1;
			apb(1'b1, `TWS_ADDR_SYNC_MODE, {3'h4, k[0], 1'b0, k[1], 2'h2});
			arm <= 1'b0;
			v = 8'h96 + k[7:0];
			apb(1'b1, `TWS_ADDR_SHIFT, v);
			wait_done(base + 1);
			chk("done pulses", base + 1, doneCnt);
			chk("clock low cycles", k[0] ? 32'd32 : 32'd16, lowCnt - lowBase);
			chk("peer got byte", {24'h0, v}, {24'h0, peerRx});
			apb(1'b0, `TWS_ADDR_SHIFT, 8'h00);
			chk("device got byte", {24'h0, 8'hC3 ^ k[7:0]}, rd);
			chk("clock idle after", 32'h1, {31'h0, serialClkOut});
		end
		// external clock: second write is refused, peer clocks the frame
		base = doneCnt;
		lsbFirst <= 1'b0;
		peerTx <= 8'hA5;
		arm <= 1'b1;
		apb(1'b1, `TWS_ADDR_SYNC_MODE, 8'h80);
		arm <= 1'b0;
		apb(1'b1, `TWS_ADDR_SHIFT, 8'h3C);
		apb(1'b1, `TWS_ADDR_SHIFT, 8'hFF);
		apb(1'b0, `TWS_ADDR_SHIFT, 8'h00);
		chk("second write kept out", 32'h3C, rd);
		apb(1'b0, `TWS_ADDR_STATUS, 8'h00);
		chk("status busy", 32'h5, rd);
		chk("clock not driven", 32'h0, {31'h0, serialClkOe});
		@(posedge mclk);
		extGo <= 1'b1;
		wait_done(base + 1);
		extGo <= 1'b0;
		chk("ext done pulses", base + 1, doneCnt);
		chk("ext peer got byte", 32'h3C, {24'h0, peerRx});
		apb(1'b0, `TWS_ADDR_SHIFT, 8'h00);
		chk("ext device got byte", 32'hA5, rd);
		report_and_stop();
	end
endmodule // tws_serial_port_tb
